/* File: rtl/spf_defines.svh */
// Constants of the four-mode serial port
// ----------------------------------------------------------------------------
// Summary of operation
// - Transmit and receive run at the same time in modes 1 to 3; mode 0 receives only with transmit idle
// - Buffer write sends; buffer read gives receive holding
// - Two mode bits pick one of four modes
// - Nine-bit multiprocessor frames with ninth zero ignored
// - Reception runs only while receive enable set
// - Nine-bit modes send tx_ninth_bit as ninth bit
// - rx_ninth_bit holds ninth bit, or mode 1 stop
// - Transmit done flag set by hardware, sticky
// - Receive done flag set by hardware, sticky
// - Software flag writes act like hardware ones
// - Either flag requests shared gated interrupt, vector 23h
// - Priority bit selects high or low group
// - Mode 0 drives shift clock, eight bits, clk/12
// - Mode 0 reception starts with flag clear, enabled
// - Mode 1 frame: start, eight data, stop
// - Mode 1 receive syncs start, stores stop bit
// - Mode 2 eleven bits at clk/64 or clk/32
// - Timer 1 rate divided by 32 or 16
// - Timer 2 selection divides by 16, ignores doubling
// - Mode 3 is mode 2 frame, timer rate
// - Fractional generator gives the mode 1 and mode 3 rate when enabled
// - Rate is clock over 16(integer+1)+fraction
// ----------------------------------------------------------------------------
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SPF_ADDR_POWER_CONTROL 8'h87
`define SPF_ADDR_SERIAL_CONTROL 8'h98
`define SPF_ADDR_SERIAL_BUFFER 8'h99
`define SPF_ADDR_FRAC_HIGH 8'h9e
`define SPF_ADDR_FRAC_LOW 8'h9f
`define SPF_ADDR_IRQ_ENABLE 8'ha8
`define SPF_ADDR_IRQ_PRIORITY 8'hb8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPF_SC_MODE_HI 7
`define SPF_SC_MODE_LO 6
`define SPF_SC_MULTIPROC 5
`define SPF_SC_RX_ENABLE 4
`define SPF_SC_TX_NINTH 3
`define SPF_SC_RX_NINTH 2
`define SPF_SC_TX_DONE 1
`define SPF_SC_RX_DONE 0
`define SPF_PC_BAUD_DOUBLE 7
`define SPF_IE_GLOBAL 7
`define SPF_IE_SERIAL 4
`define SPF_IP_SERIAL 4
`define SPF_FH_ENABLE 7

// ----------------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------------
`define SPF_RST_REG 8'h00
`define SPF_RST_FRAC 8'h00
`define SPF_MODE_SHIFT 2'h0
`define SPF_MODE_ASYNC8 2'h1
`define SPF_MODE_ASYNC9_FIXED 2'h2
`define SPF_MODE_ASYNC9_VAR 2'h3

// ----------------------------------------------------------------------------
// Timing counts and interrupt identity
// ----------------------------------------------------------------------------
`define SPF_M0_DIV 12
`define SPF_M0_HALF (`SPF_M0_DIV / 2)
`define SPF_OVERSAMPLE 16
`define SPF_M2_DIV_SLOW 64
`define SPF_M2_DIV_FAST 32
`define SPF_IRQ_VECTOR 8'h23
`define SPF_IRQ_NATURAL_PRIO 3'h5

`endif

/* File: rtl/spf_pkg.sv */
// Types of the four-mode serial port
package spf_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} spf_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} spf_rx_state_type;
endpackage : spf_pkg

/* File: rtl/spf_baud_if.sv */
// Rate configuration and tick pulses between port and rate generator
`timescale 1ns/1ns
interface spf_baud_if;
  logic [1:0] mode;
  logic baud_double;
  logic t2_tx_sel;
  logic t2_rx_sel;
  logic t1_overflow;
  logic t2_overflow;
  logic frac_enable;
  logic [10:0] frac_integer;
  logic [3:0] frac_fraction;
  logic tx_tick;
  logic rx_tick;
  logic half_tick;
  modport gen (input mode, baud_double, t2_tx_sel, t2_rx_sel, t1_overflow, t2_overflow,
    frac_enable, frac_integer, frac_fraction, output tx_tick, rx_tick, half_tick);
  modport user (output mode, baud_double, t2_tx_sel, t2_rx_sel, t1_overflow, t2_overflow,
    frac_enable, frac_integer, frac_fraction, input tx_tick, rx_tick, half_tick);
endinterface : spf_baud_if

/* File: rtl/spf_baud_gen.sv */
// Rate generator: sixteen-fold bit ticks and shift clock half ticks
`timescale 1ns/1ns
`include "spf_defines.svh"
module spf_baud_gen (
  input wire logic clk,
  input wire logic srst,
  spf_baud_if.gen bif
);
  logic [3:0] half_cnt_ff;
  logic [1:0] m2_cnt_ff;
  logic t1_div_ff;
  logic [11:0] frac_cnt_ff;
  logic [3:0] frac_acc_ff;
  logic frac_extra_ff;
  logic half_hit;
  logic m2_hit;
  logic [1:0] m2_top;
  logic t1_tick;
  logic frac_hit;
  logic [4:0] acc_sum;
  logic var_tx;
  logic var_rx;

  assign half_hit = (half_cnt_ff == 4'(`SPF_M0_HALF - 1));
  assign m2_top = bif.baud_double ? 2'(`SPF_M2_DIV_FAST / `SPF_OVERSAMPLE - 1)
                                  : 2'(`SPF_M2_DIV_SLOW / `SPF_OVERSAMPLE - 1);
  assign m2_hit = (m2_cnt_ff == m2_top);
  assign t1_tick = bif.t1_overflow & (bif.baud_double | t1_div_ff);
  assign frac_hit = (frac_cnt_ff == {1'b0, bif.frac_integer} + {11'h000, frac_extra_ff});
  assign acc_sum = {1'b0, frac_acc_ff} + {1'b0, bif.frac_fraction};
  assign var_tx = bif.frac_enable ? frac_hit
                : (bif.t2_tx_sel ? bif.t2_overflow : t1_tick);
  assign var_rx = bif.frac_enable ? frac_hit
                : (bif.t2_rx_sel ? bif.t2_overflow : t1_tick);

  // --------------------------------------------------------------------------
  // Dividers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || half_hit) begin
      half_cnt_ff <= 4'h0;
    end else begin
      half_cnt_ff <= half_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || m2_hit) begin
      m2_cnt_ff <= 2'h0;
    end else begin
      m2_cnt_ff <= m2_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      t1_div_ff <= 1'b0;
    end else if (bif.t1_overflow) begin
      t1_div_ff <= ~t1_div_ff;
    end
  end

  // Fraction spread one extra cycle over fraction ticks of every sixteen
  always_ff @(posedge clk) begin
    if (srst || !bif.frac_enable) begin
      frac_cnt_ff <= 12'h000;
      frac_acc_ff <= 4'h0;
      frac_extra_ff <= 1'b0;
    end else if (frac_hit) begin
      frac_cnt_ff <= 12'h000;
      frac_acc_ff <= acc_sum[3:0];
      frac_extra_ff <= acc_sum[4];
    end else begin
      frac_cnt_ff <= frac_cnt_ff + 12'h001;
    end
  end

  // --------------------------------------------------------------------------
  // Tick selection per mode
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      bif.tx_tick <= 1'b0;
      bif.rx_tick <= 1'b0;
      bif.half_tick <= 1'b0;
    end else begin
      bif.half_tick <= half_hit;
      case (bif.mode)
        `SPF_MODE_SHIFT: begin
          bif.tx_tick <= 1'b0;
          bif.rx_tick <= 1'b0;
        end
        `SPF_MODE_ASYNC9_FIXED: begin
          bif.tx_tick <= m2_hit;
          bif.rx_tick <= m2_hit;
        end
        default: begin
          bif.tx_tick <= var_tx;
          bif.rx_tick <= var_rx;
        end
      endcase
    end
  end
endmodule : spf_baud_gen

/* File: rtl/spf_serial_port.sv */
// Four-mode serial port with register port, full-duplex in modes 1 to 3
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "spf_defines.svh"
module spf_serial_port (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic t1_overflow,
  input wire logic t2_overflow,
  input wire logic timer2_tx_clock_select,
  input wire logic timer2_rx_clock_select,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_en,
  output logic irq_request,
  output logic irq_high_priority,
  output logic [7:0] irq_vector
);
  logic [7:0] power_control_ff;
  logic [7:0] serial_control_ff;
  logic [7:0] rx_holding_ff;
  logic [7:0] frac_high_stage_ff;
  logic [7:0] frac_high_ff;
  logic [7:0] frac_low_ff;
  logic [7:0] irq_enable_ff;
  logic [7:0] irq_priority_ff;
  logic in_meta_ff;
  logic in_sync_ff;
  logic in_prev_ff;
  spf_pkg::spf_tx_state_type tx_state_ff;
  logic [10:0] tx_shift_ff;
  logic [3:0] tx_bits_ff;
  logic [3:0] tx_sub_ff;
  logic tx_phase_ff;
  logic tx_event_ff;
  spf_pkg::spf_rx_state_type rx_state_ff;
  logic [9:0] rx_shift_ff;
  logic [3:0] rx_bits_ff;
  logic [3:0] rx_sub_ff;
  logic rx_phase_ff;
  logic rx_event_ff;
  logic rx_ninth_upd_ff;
  logic rx_ninth_val_ff;
  logic [1:0] mode;
  logic is_mode1;
  logic ren;
  logic wr_sc;
  logic wr_buf;
  logic [9:0] nxt_rx_shift;
  logic nxt_rx_ninth;
  logic [7:0] nxt_rx_data;
  logic rx_accept;

  assign mode = {serial_control_ff[`SPF_SC_MODE_HI], serial_control_ff[`SPF_SC_MODE_LO]};
  assign is_mode1 = (mode == `SPF_MODE_ASYNC8);
  assign ren = serial_control_ff[`SPF_SC_RX_ENABLE];
  assign wr_sc = reg_wr && (reg_addr == `SPF_ADDR_SERIAL_CONTROL);
  assign wr_buf = reg_wr && (reg_addr == `SPF_ADDR_SERIAL_BUFFER);

  // --------------------------------------------------------------------------
  // Rate generator
  // --------------------------------------------------------------------------
  spf_baud_if bif ();

  assign bif.mode = mode;
  assign bif.baud_double = power_control_ff[`SPF_PC_BAUD_DOUBLE];
  assign bif.t2_tx_sel = timer2_tx_clock_select;
  assign bif.t2_rx_sel = timer2_rx_clock_select;
  assign bif.t1_overflow = t1_overflow;
  assign bif.t2_overflow = t2_overflow;
  assign bif.frac_enable = frac_high_ff[`SPF_FH_ENABLE];
  assign bif.frac_integer = {frac_high_ff[6:0], frac_low_ff[7:4]};
  assign bif.frac_fraction = frac_low_ff[3:0];

  spf_baud_gen u_baud (
    .clk(clk),
    .srst(srst),
    .bif(bif.gen)
  );

  // --------------------------------------------------------------------------
  // Input synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      in_meta_ff <= 1'b1;
      in_sync_ff <= 1'b1;
      in_prev_ff <= 1'b1;
    end else begin
      in_meta_ff <= serial_in_pin;
      in_sync_ff <= in_meta_ff;
      in_prev_ff <= in_sync_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Plain registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      power_control_ff <= `SPF_RST_REG;
      irq_enable_ff <= `SPF_RST_REG;
      irq_priority_ff <= `SPF_RST_REG;
    end else if (reg_wr) begin
      case (reg_addr)
        `SPF_ADDR_POWER_CONTROL: power_control_ff <= reg_wdata;
        `SPF_ADDR_IRQ_ENABLE: irq_enable_ff <= reg_wdata;
        `SPF_ADDR_IRQ_PRIORITY: irq_priority_ff <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // High byte is staged; the low byte write applies both at once
  always_ff @(posedge clk) begin
    if (srst) begin
      frac_high_stage_ff <= `SPF_RST_FRAC;
      frac_high_ff <= `SPF_RST_FRAC;
      frac_low_ff <= `SPF_RST_FRAC;
    end else if (reg_wr && reg_addr == `SPF_ADDR_FRAC_HIGH) begin
      frac_high_stage_ff <= reg_wdata;
    end else if (reg_wr && reg_addr == `SPF_ADDR_FRAC_LOW) begin
      frac_high_ff <= frac_high_stage_ff;
      frac_low_ff <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Control register with hardware flag updates
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_control_ff <= `SPF_RST_REG;
    end else begin
      if (wr_sc) begin
        serial_control_ff <= reg_wdata;
      end
      if (tx_event_ff) begin
        serial_control_ff[`SPF_SC_TX_DONE] <= 1'b1;
      end
      if (rx_event_ff) begin
        serial_control_ff[`SPF_SC_RX_DONE] <= 1'b1;
      end
      if (rx_event_ff && rx_ninth_upd_ff) begin
        serial_control_ff[`SPF_SC_RX_NINTH] <= rx_ninth_val_ff;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_state_ff <= spf_pkg::TX_IDLE;
      tx_shift_ff <= 11'h7ff;
      tx_bits_ff <= 4'h0;
      tx_sub_ff <= 4'h0;
      tx_phase_ff <= 1'b0;
      tx_event_ff <= 1'b0;
    end else begin
      tx_event_ff <= 1'b0;
      if (wr_buf) begin
        tx_sub_ff <= 4'h0;
        tx_phase_ff <= 1'b0;
        if (mode == `SPF_MODE_SHIFT) begin
          tx_shift_ff <= {3'h7, reg_wdata};
          tx_bits_ff <= 4'h8;
          tx_state_ff <= spf_pkg::TX_SYNC;
        end else begin
          tx_shift_ff <= {1'b1, is_mode1 | serial_control_ff[`SPF_SC_TX_NINTH],
                          reg_wdata, 1'b0};
          tx_bits_ff <= is_mode1 ? 4'ha : 4'hb;
          tx_state_ff <= spf_pkg::TX_ASYNC;
        end
      end else begin
        case (tx_state_ff)
          spf_pkg::TX_ASYNC: begin
            if (bif.tx_tick) begin
              tx_sub_ff <= tx_sub_ff + 4'h1;
              if (tx_sub_ff == 4'hf) begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_bits_ff <= tx_bits_ff - 4'h1;
                if (tx_bits_ff == 4'h1) begin
                  tx_event_ff <= 1'b1;
                  tx_state_ff <= spf_pkg::TX_IDLE;
                end
              end
            end
          end
          spf_pkg::TX_SYNC: begin
            if (bif.half_tick) begin
              tx_phase_ff <= ~tx_phase_ff;
              if (tx_phase_ff) begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_bits_ff <= tx_bits_ff - 4'h1;
                if (tx_bits_ff == 4'h1) begin
                  tx_event_ff <= 1'b1;
                  tx_state_ff <= spf_pkg::TX_IDLE;
                end
              end
            end
          end
          default: begin
            tx_state_ff <= spf_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  assign nxt_rx_shift = {in_sync_ff, rx_shift_ff[9:1]};
  assign nxt_rx_data = is_mode1 ? nxt_rx_shift[8:1] : nxt_rx_shift[7:0];
  assign nxt_rx_ninth = is_mode1 ? nxt_rx_shift[9] : nxt_rx_shift[8];
  assign rx_accept = !serial_control_ff[`SPF_SC_RX_DONE]
                   && (!serial_control_ff[`SPF_SC_MULTIPROC] || nxt_rx_ninth);

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state_ff <= spf_pkg::RX_IDLE;
      rx_shift_ff <= 10'h000;
      rx_bits_ff <= 4'h0;
      rx_sub_ff <= 4'h0;
      rx_phase_ff <= 1'b0;
      rx_event_ff <= 1'b0;
      rx_ninth_upd_ff <= 1'b0;
      rx_ninth_val_ff <= 1'b0;
      rx_holding_ff <= `SPF_RST_REG;
    end else begin
      rx_event_ff <= 1'b0;
      if (!ren) begin
        rx_state_ff <= spf_pkg::RX_IDLE;
      end else begin
        case (rx_state_ff)
          spf_pkg::RX_IDLE: begin
            rx_sub_ff <= 4'h0;
            rx_phase_ff <= 1'b0;
            if (mode == `SPF_MODE_SHIFT) begin
              if (!serial_control_ff[`SPF_SC_RX_DONE] && tx_state_ff == spf_pkg::TX_IDLE) begin
                rx_bits_ff <= 4'h8;
                rx_state_ff <= spf_pkg::RX_SYNC;
              end
            end else if (!in_sync_ff && in_prev_ff) begin
              rx_state_ff <= spf_pkg::RX_START;
            end
          end
          spf_pkg::RX_START: begin
            if (bif.rx_tick) begin
              rx_sub_ff <= rx_sub_ff + 4'h1;
              if (rx_sub_ff == 4'h7) begin
                rx_sub_ff <= 4'h0;
                rx_bits_ff <= is_mode1 ? 4'h9 : 4'ha;
                // Start bit gone high at mid-bit is a glitch
                rx_state_ff <= in_sync_ff ? spf_pkg::RX_IDLE : spf_pkg::RX_DATA;
              end
            end
          end
          spf_pkg::RX_DATA: begin
            if (bif.rx_tick) begin
              rx_sub_ff <= rx_sub_ff + 4'h1;
              if (rx_sub_ff == 4'hf) begin
                rx_shift_ff <= nxt_rx_shift;
                rx_bits_ff <= rx_bits_ff - 4'h1;
                if (rx_bits_ff == 4'h1) begin
                  rx_state_ff <= spf_pkg::RX_IDLE;
                  if (rx_accept) begin
                    rx_holding_ff <= nxt_rx_data;
                    rx_event_ff <= 1'b1;
                    rx_ninth_upd_ff <= 1'b1;
                    rx_ninth_val_ff <= nxt_rx_ninth;
                  end
                end
              end
            end
          end
          spf_pkg::RX_SYNC: begin
            if (bif.half_tick) begin
              rx_phase_ff <= ~rx_phase_ff;
              if (rx_phase_ff) begin
                rx_shift_ff <= nxt_rx_shift;
                rx_bits_ff <= rx_bits_ff - 4'h1;
                if (rx_bits_ff == 4'h1) begin
                  rx_holding_ff <= nxt_rx_shift[9:2];
                  rx_event_ff <= 1'b1;
                  rx_ninth_upd_ff <= 1'b0;
                  rx_state_ff <= spf_pkg::RX_IDLE;
                end
              end
            end
          end
          default: begin
            rx_state_ff <= spf_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_out_pin <= 1'b1;
      serial_data_out_pin <= 1'b1;
      serial_data_out_en <= 1'b0;
    end else if (tx_state_ff == spf_pkg::TX_SYNC) begin
      serial_out_pin <= tx_phase_ff;
      serial_data_out_pin <= tx_shift_ff[0];
      serial_data_out_en <= 1'b1;
    end else if (rx_state_ff == spf_pkg::RX_SYNC) begin
      serial_out_pin <= rx_phase_ff;
      serial_data_out_pin <= 1'b1;
      serial_data_out_en <= 1'b0;
    end else begin
      serial_out_pin <= (tx_state_ff == spf_pkg::TX_ASYNC) ? tx_shift_ff[0] : 1'b1;
      serial_data_out_pin <= 1'b1;
      serial_data_out_en <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt request
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_request <= 1'b0;
      irq_high_priority <= 1'b0;
      irq_vector <= `SPF_IRQ_VECTOR;
    end else begin
      irq_request <= irq_enable_ff[`SPF_IE_GLOBAL] && irq_enable_ff[`SPF_IE_SERIAL]
                  && (serial_control_ff[`SPF_SC_TX_DONE]
                  || serial_control_ff[`SPF_SC_RX_DONE]);
      irq_high_priority <= irq_priority_ff[`SPF_IP_SERIAL];
      irq_vector <= `SPF_IRQ_VECTOR;
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `SPF_ADDR_POWER_CONTROL: reg_rdata <= power_control_ff;
        `SPF_ADDR_SERIAL_CONTROL: reg_rdata <= serial_control_ff;
        `SPF_ADDR_SERIAL_BUFFER: reg_rdata <= rx_holding_ff;
        `SPF_ADDR_FRAC_HIGH: reg_rdata <= frac_high_stage_ff;
        `SPF_ADDR_FRAC_LOW: reg_rdata <= frac_low_ff;
        `SPF_ADDR_IRQ_ENABLE: reg_rdata <= irq_enable_ff;
        `SPF_ADDR_IRQ_PRIORITY: reg_rdata <= irq_priority_ff;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : spf_serial_port

/* File: tb/spf_serial_port_monitor.sv */
// Port-level checker of the four-mode serial port
`timescale 1ns/1ns
module spf_serial_port_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_out_pin,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_out_en,
  input wire logic irq_request,
  input wire logic irq_high_priority,
  input wire logic [7:0] irq_vector
);
  logic [1:0] mode_ff;
  logic ie_ok_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Shadow of mode and interrupt gate
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_ff <= 2'h0;
      ie_ok_ff <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h98) begin
      mode_ff <= reg_wdata[7:6];
    end else if (reg_wr && reg_addr == 8'ha8) begin
      ie_ok_ff <= reg_wdata[7] && reg_wdata[4];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  vector_fixed_a: assert property (irq_vector == 8'h23)
    else $error("vector changed");
  read_window_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside window");
  start_low_a: assert property (reg_wr && reg_addr == 8'h99 |-> ##2 !serial_out_pin)
    else $error("no transfer after buffer write");
  prio_follow_a: assert property (reg_wr && reg_addr == 8'hb8 |-> ##2
    irq_high_priority == $past(reg_wdata[4], 2)) else $error("priority mismatch");
  irq_gated_a: assert property (irq_request |-> $past(ie_ok_ff))
    else $error("request while gated");
  data_idle_a: assert property (!serial_data_out_en |-> serial_data_out_pin)
    else $error("data pin not idle");
  shift_high_a: assert property (serial_data_out_en && $rose(serial_out_pin)
    |-> serial_out_pin[*6]) else $error("shift clock high phase");
  async_bit_a: assert property (mode_ff != 2'h0 && $fell(serial_out_pin)
    |-> !serial_out_pin[*8]) else $error("short bit");
  cover property ($rose(irq_request));
  cover property ($rose(serial_data_out_en));
  cover property (mode_ff == 2'h2 && $fell(serial_out_pin));
endmodule : spf_serial_port_monitor

bind spf_serial_port spf_serial_port_monitor spf_serial_port_monitor_i (.*);

/* File: tb/spf_remote_model.sv */
// Remote serial transmitter driving the receive line
`timescale 1ns/1ns
module spf_remote_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [10:0] frame,
  input wire logic [3:0] nbits,
  input wire logic [7:0] bit_clks,
  output logic rxd
);
  initial rxd = 1'b1;
  // Frame bits go out least significant first
  always @(posedge clk) begin
    if (go) begin
      for (int i = 0; i < nbits; i++) begin
        rxd <= frame[i];
        repeat (bit_clks) @(posedge clk);
      end
    end
  end
endmodule : spf_remote_model

/* File: tb/test_spf_serial_port.sv */
// Self-checking bench of the four-mode serial port
`timescale 1ns/1ns
module test_spf_serial_port;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic t2_tx = 1'b0;
  logic t2_rx = 1'b0;
  logic [7:0] bc = 8'h20;
  logic go = 1'b0;
  logic [7:0] reg_rdata, d, v;
  logic rxd, sout, dout, den, irq, ps;
  logic [10:0] frame = 11'h7ff;
  logic [10:0] f;
  logic [3:0] nb = 4'hb;
  logic [1:0] c = 2'h0;
  logic [7:0] ra [7] = '{8'h87, 8'h98, 8'h99, 8'h9e, 8'h9f, 8'ha8, 8'hb8};
  int failures = 0;
  int comparisons = 0;
  int n;
  always #20 clk = ~clk;
  // Timer pulses every 2 and every 4 clocks
  always @(posedge clk) begin
    c <= c + 2'h1;
    t1 <= ~t1;
    t2 <= (c == 2'h0);
  end
  spf_serial_port spf_serial_port_i (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .t1_overflow(t1), .t2_overflow(t2), .timer2_tx_clock_select(t2_tx),
    .timer2_rx_clock_select(t2_rx), .serial_in_pin(rxd), .serial_out_pin(sout),
    .serial_data_out_pin(dout), .serial_data_out_en(den), .irq_request(irq),
    .irq_high_priority(), .irq_vector());
  spf_remote_model spf_remote_model_i (.clk, .go, .frame, .nbits(nb), .bit_clks(bc), .rxd);
  function automatic logic [10:0] fr(input logic [7:0] x, input logic b9, input logic m1);
    return m1 ? {2'b01, x, 1'b0} : {1'b1, b9, x, 1'b0};
  endfunction : fr
  task automatic summarize();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({3'h0, reg_rdata}, {3'h0, e});
  endtask : rc
  task automatic ckirq(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({10'h0, irq}, {10'h0, e});
  endtask : ckirq
  task automatic send(input logic [10:0] x, input logic [3:0] k);
    @(posedge clk);
    frame <= x;
    nb <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : send
  // Wait for start bit, then sample each bit in its middle
  task automatic txcap(input int k, input int b, output logic [10:0] q);
    int w;
    q = 11'h000;
    w = 0;
    while (sout === 1'b1 && w < 3000) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (w == 3000) begin
      failures++;
      summarize();
    end
    repeat (b / 2) @(posedge clk);
    for (int i = 0; i < k; i++) begin
      #1 q[i] = sout;
      repeat (b) @(posedge clk);
    end
  endtask : txcap
  initial begin
    void'($urandom(82646));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[i]) rc(ra[i], 8'h00);
    for (int i = 0; i < 7; i += 3) begin
      d = 8'($urandom);
      wr(ra[i], d);
      rc(ra[i], d);
    end
    wr(8'h55, 8'hff);
    rc(8'h55, 8'h00);
    wr(8'h87, 8'h80);
    wr(8'h98, 8'hb8);
    d = 8'($urandom);
    send(fr(d, 1'b0, 1'b0), 4'hb);
    repeat (400) @(posedge clk);
    rc(8'h98, 8'hb8);
    d = 8'($urandom);
    v = 8'($urandom);
    send(fr(d, 1'b1, 1'b0), 4'hb);
    wr(8'h99, v);
    txcap(11, 32, f);
    chk(f, fr(v, 1'b1, 1'b0));
    repeat (60) @(posedge clk);
    rc(8'h98, 8'hbf);
    rc(8'h99, d);
    wr(8'ha8, 8'h90);
    ckirq(1'b1);
    wr(8'h98, 8'hb8);
    ckirq(1'b0);
    wr(8'h98, 8'hb9);
    ckirq(1'b1);
    wr(8'ha8, 8'h10);
    ckirq(1'b0);
    wr(8'h98, 8'h80);
    send(fr(d, 1'b1, 1'b0), 4'hb);
    repeat (400) @(posedge clk);
    rc(8'h98, 8'h80);
    wr(8'h98, 8'h50);
    d = 8'($urandom);
    send(fr(d, 1'b0, 1'b1), 4'ha);
    repeat (400) @(posedge clk);
    rc(8'h98, 8'h55);
    rc(8'h99, d);
    t2_tx <= 1'b1;
    t2_rx <= 1'b1;
    bc <= 8'h40;
    wr(8'h98, 8'h50);
    d = 8'($urandom);
    send(fr(d, 1'b0, 1'b1), 4'ha);
    wr(8'h99, v);
    txcap(10, 64, f);
    chk(f, fr(v, 1'b0, 1'b1));
    rc(8'h98, 8'h57);
    rc(8'h99, d);
    t2_tx <= 1'b0;
    t2_rx <= 1'b0;
    wr(8'h9e, 8'h80);
    wr(8'h9f, 8'h25);
    rc(8'h9f, 8'h25);
    wr(8'h99, v);
    txcap(10, 53, f);
    chk(f, fr(v, 1'b0, 1'b1));
    wr(8'h98, 8'h00);
    v = 8'($urandom);
    f = 11'h000;
    n = 0;
    ps = 1'b1;
    wr(8'h99, v);
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      #1;
      if (ps === 1'b0 && sout === 1'b1 && n < 8) begin
        f[n] = dout;
        n++;
      end
      ps = sout;
    end
    chk(f, {3'h0, v});
    wr(8'h98, 8'h10);
    repeat (150) @(posedge clk);
    rc(8'h98, 8'h11);
    rc(8'h99, 8'hff);
    summarize();
  end
endmodule : test_spf_serial_port
